//--- verilog/lvl_out_pkg.sv
// shared constants, register map and state types of the level output signal generator
package lvl_out_pkg;

    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam logic [43:0] HALF_CLK_HZ   = 44'(CLK_HZ / 2);
    localparam logic [11:0] FMAX_LIMIT_HZ = 12'hbb8;
    localparam logic [31:0] MM_PER_M      = 32'h0000_03e8;

    localparam int unsigned MAX_UNIV  = 9;
    localparam int unsigned MAX_CUR   = 2;
    localparam int unsigned N_CHAN    = 2;
    localparam int unsigned N_COND    = 4;
    localparam int unsigned N_PARAM   = 4;

    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_ACOUSTIC  = 8'h01;
    localparam logic [7:0] ADDR_COND_BASE = 8'h02;
    localparam logic [7:0] ADDR_UNIV_BASE = 8'h10;
    localparam logic [7:0] ADDR_CUR_BASE  = 8'h40;
    localparam logic [7:0] ADDR_STATUS    = 8'h60;

    localparam logic [1:0] SUB_CFG   = 2'h0;
    localparam logic [1:0] SUB_LT    = 2'h1;
    localparam logic [1:0] SUB_UT    = 2'h2;
    localparam logic [1:0] SUB_EXTRA = 2'h3;

    localparam int unsigned COND_ABOVE_BIT = 16;
    localparam int unsigned UCFG_HIGH_BIT  = 2;
    localparam int unsigned UCFG_FUNC_LSB  = 3;
    localparam int unsigned UCFG_PSEL_LSB  = 7;
    localparam int unsigned CCFG_PSEL_LSB  = 2;
    localparam int unsigned KC_LSB         = 16;

    localparam logic [14:0] CUR_0MA_UA  = 15'h0000;
    localparam logic [14:0] CUR_4MA_UA  = 15'h0fa0;
    localparam logic [14:0] CUR_5MA_UA  = 15'h1388;
    localparam logic [14:0] CUR_20MA_UA = 15'h4e20;

    typedef enum logic [1:0] {
        UMODE_OFF   = 2'b00,
        UMODE_FREQ  = 2'b01,
        UMODE_LOGIC = 2'b10,
        UMODE_RSVD  = 2'b11
    } umode_t;

    typedef enum logic [1:0] {
        CRANGE_0_5   = 2'b00,
        CRANGE_0_20  = 2'b01,
        CRANGE_4_20  = 2'b10,
        CRANGE_RSVD  = 2'b11
    } crange_t;

    localparam logic [3:0] FUNC_NONE     = 4'h0;
    localparam logic [3:0] FUNC_ACOUSTIC = 4'h9;

    typedef struct packed {
        umode_t      mode;
        logic        act_high;
        logic [3:0]  func;
        logic [1:0]  psel;
        logic [15:0] lt;
        logic [15:0] ut;
        logic [11:0] fmax;
    } ucfg_t;

    typedef struct packed {
        crange_t     range;
        logic [1:0]  psel;
        logic [15:0] lt;
        logic [15:0] ut;
    } ccfg_t;

    typedef struct packed {
        logic        above;
        logic [15:0] value;
    } cond_t;

    typedef struct packed {
        ucfg_t [MAX_UNIV-1:0]          ucfg;
        ccfg_t [MAX_CUR-1:0]           ccfg;
        cond_t [N_CHAN-1:0][N_COND-1:0] cond;
        logic                          cond_act;
        logic                          ac_en;
        logic                          ac_chan;
        logic [MAX_UNIV-1:0]           logic_pin;
        logic [31:0]                   rdata;
    } lvl_state_t;

    typedef struct packed {
        logic [43:0] acc;
        logic        pin;
        logic [31:0] kc;
    } freq_state_t;

    typedef struct packed {
        logic [14:0] ua;
    } cur_state_t;

    localparam ucfg_t      UCFG_RST  = '0;
    localparam ccfg_t      CCFG_RST  = '0;
    localparam lvl_state_t LVL_RST   = '0;
    localparam freq_state_t FREQ_RST = '0;
    localparam cur_state_t CUR_RST   = '0;

endpackage

//--- verilog/freq_out_gen.sv
// square wave generator whose rate scales linearly between two thresholds
`timescale 1ns/100ps
`default_nettype none
module freq_out_gen (
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_en,
    input  wire logic [15:0] i_value,
    input  wire logic [15:0] i_lt,
    input  wire logic [15:0] i_ut,
    input  wire logic [11:0] i_fmax,
    output logic             o_pulse,
    output logic [31:0]      o_kc
);
    lvl_out_pkg::freq_state_t s_r;
    lvl_out_pkg::freq_state_t s_nxt;
    logic [15:0] span;
    logic [15:0] offs;
    logic [43:0] inc;
    logic [43:0] thr;
    logic [43:0] sum;
    logic        valid;

    always_comb begin
        s_nxt = s_r;
        span  = i_ut - i_lt;
        valid = i_en && (i_ut > i_lt);
        if (i_value <= i_lt) begin
            offs = 16'h0000;
        end else if (i_value >= i_ut) begin
            offs = span;
        end else begin
            offs = i_value - i_lt;
        end
        inc = 44'(i_fmax) * 44'(offs);
        thr = 44'(span) * lvl_out_pkg::HALF_CLK_HZ;
        sum = s_r.acc + inc;
        if (!valid || offs == 16'h0000) begin
            s_nxt.acc = '0;
            s_nxt.pin = 1'b0;
        end else if (sum >= thr) begin
            // toggling every half period keeps high and low time equal
            s_nxt.acc = sum - thr;
            s_nxt.pin = ~s_r.pin;
        end else begin
            s_nxt.acc = sum;
        end
        if (valid) begin
            s_nxt.kc = (32'(i_fmax) * lvl_out_pkg::MM_PER_M) / 32'(span);
        end else begin
            s_nxt.kc = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s_r <= lvl_out_pkg::FREQ_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_pulse = s_r.pin;
    assign o_kc    = s_r.kc;
endmodule
`default_nettype wire

//--- verilog/cur_out_gen.sv
// linear mapping of a measured parameter onto a current range, in microamperes
`timescale 1ns/100ps
`default_nettype none
module cur_out_gen (
    input  wire logic                 i_mclk,
    input  wire logic                 i_sys_rst,
    input  wire lvl_out_pkg::crange_t i_range,
    input  wire logic [15:0]          i_value,
    input  wire logic [15:0]          i_lt,
    input  wire logic [15:0]          i_ut,
    output logic [14:0]               o_ua
);
    lvl_out_pkg::cur_state_t s_r;
    lvl_out_pkg::cur_state_t s_nxt;
    logic [14:0] imin;
    logic [14:0] imax;
    logic [15:0] span;
    logic [15:0] offs;
    logic [31:0] part;

    always_comb begin
        unique case (i_range)
            lvl_out_pkg::CRANGE_0_5: begin
                imin = lvl_out_pkg::CUR_0MA_UA;
                imax = lvl_out_pkg::CUR_5MA_UA;
            end
            lvl_out_pkg::CRANGE_0_20: begin
                imin = lvl_out_pkg::CUR_0MA_UA;
                imax = lvl_out_pkg::CUR_20MA_UA;
            end
            default: begin
                imin = lvl_out_pkg::CUR_4MA_UA;
                imax = lvl_out_pkg::CUR_20MA_UA;
            end
        endcase
        span = i_ut - i_lt;
        if (i_value <= i_lt) begin
            offs = 16'h0000;
        end else if (i_value >= i_ut) begin
            offs = span;
        end else begin
            offs = i_value - i_lt;
        end
        if (i_ut > i_lt) begin
            part = (32'(imax - imin) * 32'(offs)) / 32'(span);
        end else begin
            part = 32'h0000_0000;
        end
        s_nxt.ua = imin + part[14:0];
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s_r <= lvl_out_pkg::CUR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_ua = s_r.ua;
endmodule
`default_nettype wire

//--- verilog/level_output_signal_generator.sv
// level output signal generator: register file, logic conditions, frequency and current outputs
//
// Behaviour
// - frequency mode emits a square wave, period twice the pulse width
// - pulse rate rises in proportion to the measured level
// - lower threshold gives 0 Hz, upper threshold gives the set maximum frequency
// - maximum frequency setting is limited to 3000 Hz
// - pulses per metre scale factor is computed from thresholds and maximum frequency
// - logic mode drives one level on event, the other otherwise, polarity selectable
// - each logic output picks one of ten functions; none keeps it locked
// - four level conditions per channel plus one acoustic presence condition are stored
// - when activated, level is compared with the four values and outputs asserted
// - between one and nine isolated universal outputs exist
// - one or two current outputs exist
// - each current output uses 0-5, 0-20 or 4-20 mA
// - current is linear: lower threshold gives range minimum, upper gives maximum
// - current outputs select from the same measured parameters as frequency outputs
`timescale 1ns/100ps
`default_nettype none
module level_output_signal_generator #(
    parameter int unsigned N_UNIV = 9,
    parameter int unsigned N_CUR  = 2
) (
    input  wire logic                                       i_mclk,
    input  wire logic                                       i_sys_rst,
    input  wire logic [7:0]                                 i_addr,
    input  wire logic [31:0]                                i_wdata,
    input  wire logic                                       i_wr,
    input  wire logic                                       i_rd,
    output logic [31:0]                                     o_rdata,
    input  wire logic [lvl_out_pkg::N_PARAM-1:0][15:0]      i_meas,
    input  wire logic [lvl_out_pkg::N_CHAN-1:0]             i_echo_ok,
    output logic [N_UNIV-1:0]                               o_univ,
    output logic [N_CUR-1:0][14:0]                          o_cur_ua
);
    lvl_out_pkg::lvl_state_t s_r;
    lvl_out_pkg::lvl_state_t s_nxt;

    logic [lvl_out_pkg::MAX_UNIV-1:0]        freq_pin;
    logic [lvl_out_pkg::MAX_UNIV-1:0][31:0]  freq_kc;
    logic [lvl_out_pkg::MAX_CUR-1:0][14:0]   cur_ua;
    logic [lvl_out_pkg::N_CHAN-1:0][lvl_out_pkg::N_COND-1:0] cond_met;
    logic [lvl_out_pkg::MAX_UNIV-1:0]        univ_pin;
    logic                                    event_on;
    logic [7:0]                              rel;
    logic [3:0]                              slot;
    logic [1:0]                              sub;

    // word address relative to a block base: slot index and field inside the slot
    function automatic logic [7:0] addr_rel(input logic [7:0] a, input logic [7:0] base);
        addr_rel = a - base;
    endfunction

    function automatic logic [15:0] pick_meas(input logic [1:0] sel,
                                              input logic [lvl_out_pkg::N_PARAM-1:0][15:0] m);
        pick_meas = m[sel];
    endfunction

    // event for one of the ten logic functions
    function automatic logic func_event(input logic [3:0] f,
                                        input logic [lvl_out_pkg::N_CHAN-1:0][lvl_out_pkg::N_COND-1:0] met,
                                        input logic ac_en,
                                        input logic ac_ch,
                                        input logic [lvl_out_pkg::N_CHAN-1:0] echo);
        logic [3:0] k;
        k = f - 4'h1;
        if (f == lvl_out_pkg::FUNC_NONE || f > lvl_out_pkg::FUNC_ACOUSTIC) begin
            func_event = 1'b0;
        end else if (f == lvl_out_pkg::FUNC_ACOUSTIC) begin
            func_event = ac_en && echo[ac_ch];
        end else begin
            func_event = met[k[2]][k[1:0]];
        end
    endfunction

    // condition evaluation against the stored values
    always_comb begin
        for (int c = 0; c < lvl_out_pkg::N_CHAN; c++) begin
            for (int k = 0; k < lvl_out_pkg::N_COND; k++) begin
                if (s_r.cond[c][k].above) begin
                    cond_met[c][k] = s_r.cond_act && (i_meas[c] >= s_r.cond[c][k].value);
                end else begin
                    cond_met[c][k] = s_r.cond_act && (i_meas[c] <= s_r.cond[c][k].value);
                end
            end
        end
    end

    always_comb begin
        s_nxt       = s_r;
        s_nxt.rdata = 32'h0000_0000;
        event_on    = 1'b0;
        rel         = 8'h00;
        slot        = 4'h0;
        sub         = 2'h0;

        // logic mode output levels
        for (int u = 0; u < lvl_out_pkg::MAX_UNIV; u++) begin
            event_on = func_event(s_r.ucfg[u].func, cond_met, s_r.ac_en, s_r.ac_chan, i_echo_ok);
            if (u >= N_UNIV || s_r.ucfg[u].mode != lvl_out_pkg::UMODE_LOGIC) begin
                s_nxt.logic_pin[u] = 1'b0;
            end else if (s_r.ucfg[u].func == lvl_out_pkg::FUNC_NONE) begin
                s_nxt.logic_pin[u] = ~s_r.ucfg[u].act_high;
            end else begin
                s_nxt.logic_pin[u] = event_on ? s_r.ucfg[u].act_high : ~s_r.ucfg[u].act_high;
            end
        end

        // register writes
        if (i_wr) begin
            if (i_addr == lvl_out_pkg::ADDR_CTRL) begin
                s_nxt.cond_act = i_wdata[0];
            end else if (i_addr == lvl_out_pkg::ADDR_ACOUSTIC) begin
                s_nxt.ac_en   = i_wdata[0];
                s_nxt.ac_chan = i_wdata[1];
            end else if (i_addr >= lvl_out_pkg::ADDR_COND_BASE &&
                         i_addr < lvl_out_pkg::ADDR_COND_BASE + 8'(lvl_out_pkg::N_CHAN * lvl_out_pkg::N_COND)) begin
                rel = addr_rel(i_addr, lvl_out_pkg::ADDR_COND_BASE);
                s_nxt.cond[rel[2]][rel[1:0]].value = i_wdata[15:0];
                s_nxt.cond[rel[2]][rel[1:0]].above = i_wdata[lvl_out_pkg::COND_ABOVE_BIT];
            end else if (i_addr >= lvl_out_pkg::ADDR_UNIV_BASE &&
                         i_addr < lvl_out_pkg::ADDR_UNIV_BASE + 8'(4 * N_UNIV)) begin
                rel  = addr_rel(i_addr, lvl_out_pkg::ADDR_UNIV_BASE);
                slot = rel[5:2];
                sub  = rel[1:0];
                unique case (sub)
                    lvl_out_pkg::SUB_CFG: begin
                        s_nxt.ucfg[slot].mode     = lvl_out_pkg::umode_t'(i_wdata[1:0]);
                        s_nxt.ucfg[slot].act_high = i_wdata[lvl_out_pkg::UCFG_HIGH_BIT];
                        s_nxt.ucfg[slot].func     = i_wdata[lvl_out_pkg::UCFG_FUNC_LSB +: 4];
                        s_nxt.ucfg[slot].psel     = i_wdata[lvl_out_pkg::UCFG_PSEL_LSB +: 2];
                    end
                    lvl_out_pkg::SUB_LT: begin
                        s_nxt.ucfg[slot].lt = i_wdata[15:0];
                    end
                    lvl_out_pkg::SUB_UT: begin
                        s_nxt.ucfg[slot].ut = i_wdata[15:0];
                    end
                    lvl_out_pkg::SUB_EXTRA: begin
                        if (i_wdata[11:0] > lvl_out_pkg::FMAX_LIMIT_HZ) begin
                            s_nxt.ucfg[slot].fmax = lvl_out_pkg::FMAX_LIMIT_HZ;
                        end else begin
                            s_nxt.ucfg[slot].fmax = i_wdata[11:0];
                        end
                    end
                endcase
            end else if (i_addr >= lvl_out_pkg::ADDR_CUR_BASE &&
                         i_addr < lvl_out_pkg::ADDR_CUR_BASE + 8'(4 * N_CUR)) begin
                rel  = addr_rel(i_addr, lvl_out_pkg::ADDR_CUR_BASE);
                slot = rel[5:2];
                sub  = rel[1:0];
                unique case (sub)
                    lvl_out_pkg::SUB_CFG: begin
                        s_nxt.ccfg[slot[0]].range = lvl_out_pkg::crange_t'(i_wdata[1:0]);
                        s_nxt.ccfg[slot[0]].psel  = i_wdata[lvl_out_pkg::CCFG_PSEL_LSB +: 2];
                    end
                    lvl_out_pkg::SUB_LT: begin
                        s_nxt.ccfg[slot[0]].lt = i_wdata[15:0];
                    end
                    lvl_out_pkg::SUB_UT: begin
                        s_nxt.ccfg[slot[0]].ut = i_wdata[15:0];
                    end
                    lvl_out_pkg::SUB_EXTRA: begin
                        // current readback is read only
                        s_nxt.ccfg[slot[0]] = s_r.ccfg[slot[0]];
                    end
                endcase
            end
        end

        // register reads; data stand in the following cycle only
        if (i_rd) begin
            if (i_addr == lvl_out_pkg::ADDR_CTRL) begin
                s_nxt.rdata = {31'h0, s_r.cond_act};
            end else if (i_addr == lvl_out_pkg::ADDR_ACOUSTIC) begin
                s_nxt.rdata = {30'h0, s_r.ac_chan, s_r.ac_en};
            end else if (i_addr >= lvl_out_pkg::ADDR_COND_BASE &&
                         i_addr < lvl_out_pkg::ADDR_COND_BASE + 8'(lvl_out_pkg::N_CHAN * lvl_out_pkg::N_COND)) begin
                rel = addr_rel(i_addr, lvl_out_pkg::ADDR_COND_BASE);
                s_nxt.rdata = {15'h0, s_r.cond[rel[2]][rel[1:0]]};
            end else if (i_addr >= lvl_out_pkg::ADDR_UNIV_BASE &&
                         i_addr < lvl_out_pkg::ADDR_UNIV_BASE + 8'(4 * N_UNIV)) begin
                rel  = addr_rel(i_addr, lvl_out_pkg::ADDR_UNIV_BASE);
                slot = rel[5:2];
                sub  = rel[1:0];
                unique case (sub)
                    lvl_out_pkg::SUB_CFG: begin
                        s_nxt.rdata = {23'h0, s_r.ucfg[slot].psel, s_r.ucfg[slot].func,
                                       s_r.ucfg[slot].act_high, s_r.ucfg[slot].mode};
                    end
                    lvl_out_pkg::SUB_LT: begin
                        s_nxt.rdata = {16'h0, s_r.ucfg[slot].lt};
                    end
                    lvl_out_pkg::SUB_UT: begin
                        s_nxt.rdata = {16'h0, s_r.ucfg[slot].ut};
                    end
                    lvl_out_pkg::SUB_EXTRA: begin
                        s_nxt.rdata = {freq_kc[slot][15:0], 4'h0, s_r.ucfg[slot].fmax};
                    end
                endcase
            end else if (i_addr >= lvl_out_pkg::ADDR_CUR_BASE &&
                         i_addr < lvl_out_pkg::ADDR_CUR_BASE + 8'(4 * N_CUR)) begin
                rel  = addr_rel(i_addr, lvl_out_pkg::ADDR_CUR_BASE);
                slot = rel[5:2];
                sub  = rel[1:0];
                unique case (sub)
                    lvl_out_pkg::SUB_CFG: begin
                        s_nxt.rdata = {28'h0, s_r.ccfg[slot[0]].psel, s_r.ccfg[slot[0]].range};
                    end
                    lvl_out_pkg::SUB_LT: begin
                        s_nxt.rdata = {16'h0, s_r.ccfg[slot[0]].lt};
                    end
                    lvl_out_pkg::SUB_UT: begin
                        s_nxt.rdata = {16'h0, s_r.ccfg[slot[0]].ut};
                    end
                    lvl_out_pkg::SUB_EXTRA: begin
                        s_nxt.rdata = {17'h0, cur_ua[slot[0]]};
                    end
                endcase
            end else if (i_addr == lvl_out_pkg::ADDR_STATUS) begin
                s_nxt.rdata = {23'h0, univ_pin};
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s_r <= lvl_out_pkg::LVL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // one frequency generator per universal output slot
    for (genvar u = 0; u < lvl_out_pkg::MAX_UNIV; u++) begin : g_univ
        freq_out_gen u_freq (
            .i_mclk    (i_mclk),
            .i_sys_rst (i_sys_rst),
            .i_en      ((u < N_UNIV) && (s_r.ucfg[u].mode == lvl_out_pkg::UMODE_FREQ)),
            .i_value   (pick_meas(s_r.ucfg[u].psel, i_meas)),
            .i_lt      (s_r.ucfg[u].lt),
            .i_ut      (s_r.ucfg[u].ut),
            .i_fmax    (s_r.ucfg[u].fmax),
            .o_pulse   (freq_pin[u]),
            .o_kc      (freq_kc[u])
        );
        assign univ_pin[u] = (s_r.ucfg[u].mode == lvl_out_pkg::UMODE_FREQ) ? freq_pin[u] : s_r.logic_pin[u];
    end

    for (genvar c = 0; c < lvl_out_pkg::MAX_CUR; c++) begin : g_cur
        cur_out_gen u_cur (
            .i_mclk    (i_mclk),
            .i_sys_rst (i_sys_rst),
            .i_range   (s_r.ccfg[c].range),
            .i_value   (pick_meas(s_r.ccfg[c].psel, i_meas)),
            .i_lt      (s_r.ccfg[c].lt),
            .i_ut      (s_r.ccfg[c].ut),
            .o_ua      (cur_ua[c])
        );
    end

    assign o_univ   = univ_pin[N_UNIV-1:0];
    assign o_cur_ua = cur_ua[N_CUR-1:0];
    assign o_rdata  = s_r.rdata;
endmodule
`default_nettype wire

//--- sim/pulse_rx.sv
// receiver model that measures the high time of one square wave output
`timescale 1ns/100ps
`default_nettype none
module pulse_rx (
    input  wire logic    i_mclk,
    input  wire logic    i_sig,
    output logic [31:0]  o_high
);
    logic [31:0] cnt_r = '0;
    logic        prev_r = 1'b0;
    logic [31:0] high_r = '0;
    assign o_high = high_r;
    // counts the cycles of one high phase and reports it on the falling edge
    always @(posedge i_mclk) begin
        prev_r <= i_sig;
        if (i_sig)
            cnt_r <= prev_r ? cnt_r + 32'h1 : 32'h1;
        if (!i_sig && prev_r)
            high_r <= cnt_r;
    end
endmodule
`default_nettype wire

//--- sim/lvl_out_chk_asserts.sv
// port level assertions of the level output signal generator
`timescale 1ns/100ps
`default_nettype none
module lvl_out_chk #(
    parameter int unsigned N_UNIV = 9,
    parameter int unsigned N_CUR  = 2
) (
    input wire logic                                  i_mclk,
    input wire logic                                  i_sys_rst,
    input wire logic [7:0]                            i_addr,
    input wire logic [31:0]                           i_wdata,
    input wire logic                                  i_wr,
    input wire logic                                  i_rd,
    input wire logic [31:0]                           o_rdata,
    input wire logic [lvl_out_pkg::N_PARAM-1:0][15:0] i_meas,
    input wire logic [lvl_out_pkg::N_CHAN-1:0]        i_echo_ok,
    input wire logic [N_UNIV-1:0]                     o_univ,
    input wire logic [N_CUR-1:0][14:0]                o_cur_ua
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    a_rdata_idle:
        assert property (!$past(i_rd) |-> o_rdata == '0) else $error("read data outside answer cycle");
    a_unmapped_zero:
        assert property (i_rd && i_addr > 8'h60 |=> o_rdata == '0) else $error("unmapped read not zero");
    a_fmax_capped:
        assert property (i_rd && i_addr inside {[8'h10:8'h33]} && i_addr[1:0] == 2'h3
            |=> o_rdata[11:0] <= 12'hbb8) else $error("maximum frequency above limit");
    a_cur_read_cap:
        assert property (i_rd && i_addr inside {8'h43, 8'h47} |=> o_rdata <= 32'h4e20)
            else $error("current readback above range");
    a_status_width:
        assert property (i_rd && i_addr == 8'h60 |=> o_rdata[31:9] == '0) else $error("status beyond nine pins");
    a_cur_port_cap:
        assert property (o_cur_ua[0] <= 15'h4e20 && o_cur_ua[N_CUR-1] <= 15'h4e20)
            else $error("current set point above range");
    a_reset_quiet:
        assert property ($fell(i_sys_rst) |-> o_univ == '0 && o_cur_ua == '0) else $error("outputs active after reset");
    a_cur_settles:
        assert property ((!i_wr && $stable(i_meas)) [*3] |=> $stable(o_cur_ua))
            else $error("current moves with steady inputs");
    c_read: cover property (i_rd ##1 o_rdata != '0);
    c_wave: cover property ($rose(o_univ[0]));
    c_full: cover property (o_cur_ua[0] == 15'h4e20);
endmodule
bind level_output_signal_generator lvl_out_chk #(.N_UNIV(N_UNIV), .N_CUR(N_CUR)) chk_u (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_meas(i_meas), .i_echo_ok(i_echo_ok), .o_univ(o_univ), .o_cur_ua(o_cur_ua));
`default_nettype wire

//--- sim/test_level_output_signal_generator.sv
// self-checking bench for the level output signal generator
`timescale 1ns/100ps
`default_nettype none
module test_level_output_signal_generator;
    logic                                  i_mclk, i_sys_rst, i_wr, i_rd;
    logic [7:0]                            i_addr;
    logic [31:0]                           i_wdata, o_rdata, d, high_w;
    logic [lvl_out_pkg::N_PARAM-1:0][15:0] i_meas;
    logic [1:0]                            i_echo_ok;
    logic [8:0]                            o_univ;
    logic [1:0][14:0]                      o_cur_ua;
    int                                    n_errors = 0;
    int                                    n_checks = 0;
    int                                    vt[3] = '{50, 550, 2000};
    level_output_signal_generator dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_meas(i_meas),
        .i_echo_ok(i_echo_ok), .o_univ(o_univ), .o_cur_ua(o_cur_ua));
    pulse_rx rx_u (.i_mclk(i_mclk), .i_sig(o_univ[0]), .o_high(high_w));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        v = o_rdata;
    endtask
    // drives both channel levels and looks at logic output one
    task automatic lvl(input logic [15:0] v, input logic e);
        @(posedge i_mclk);
        i_meas[0] <= v;
        i_meas[1] <= v;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        chk("logic pin", {31'h0, e}, {31'h0, o_univ[1]});
    endtask
    function automatic logic [31:0] ua(input int r, input int v);
        int lo;
        int hi;
        lo = (r == 2) ? 4000 : 0;
        hi = (r == 0) ? 5000 : 20000;
        if (v <= 100)
            return lo;
        if (v >= 1100)
            return hi;
        return lo + (hi - lo) * (v - 100) / 1000;
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (95000) @(posedge i_mclk);
        n_errors++;
        conclude();
    end
    initial begin
        i_sys_rst = 1'b1;
        {i_wr, i_rd, i_addr, i_wdata, i_echo_ok} = '0;
        i_meas = '0;
        repeat (10) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(negedge i_mclk);
        chk("pins", 32'h0, 32'(o_univ));
        chk("current", 32'h0, 32'(o_cur_ua));
        rd(8'h10, d);
        chk("cfg reset", 32'h0, d);
        rd(8'h7f, d);
        chk("unmapped", 32'h0, d);
        $display("reset test done");
        wr(8'h00, 32'h1);
        for (int k = 0; k < 8; k++)
            wr(8'h02 + 8'(k), 32'h1_01f4);
        for (int f = 1; f <= 10; f++) begin
            wr(8'h14, 32'(f) << 3 | 32'h6);
            lvl(16'd600, f < 9);
            lvl(16'd400, 1'b0);
        end
        wr(8'h14, 32'h0a);
        lvl(16'd600, 1'b0);
        wr(8'h14, 32'h02);
        lvl(16'd600, 1'b1);
        wr(8'h14, 32'h0e);
        wr(8'h00, 32'h0);
        lvl(16'd600, 1'b0);
        wr(8'h01, 32'h1);
        wr(8'h14, 32'h4e);
        i_echo_ok <= 2'b01;
        lvl(16'd600, 1'b1);
        rd(8'h60, d);
        chk("status", 32'h2, d);
        i_echo_ok <= 2'b10;
        lvl(16'd600, 1'b0);
        $display("logic test done");
        wr(8'h41, 32'd100);
        wr(8'h42, 32'd1100);
        for (int r = 0; r < 3; r++) begin
            wr(8'h40, 32'(r) | 32'h8);
            foreach (vt[j]) begin
                @(posedge i_mclk);
                i_meas[2] <= vt[j][15:0];
                rd(8'h43, d);
                rd(8'h43, d);
                chk("current reg", ua(r, vt[j]), d);
                chk("current pin", ua(r, vt[j]), 32'(o_cur_ua[0]));
            end
        end
        $display("current test done");
        wr(8'h12, 32'd1000);
        i_meas[0] <= 16'd0;
        wr(8'h13, 32'hfff);
        wr(8'h10, 32'h1);
        rd(8'h13, d);
        chk("fmax", 32'hbb8, {20'h0, d[11:0]});
        chk("scale", 32'd3000, {16'h0, d[31:16]});
        repeat (300) @(posedge i_mclk);
        chk("idle pin", 32'h0, {31'h0, o_univ[0]});
        i_meas[0] <= 16'd2000;
        for (int i = 0; i < 80000 && high_w == 0; i++)
            @(posedge i_mclk);
        chk("half period", 32'h1, {31'h0, high_w >= 33332 && high_w <= 33335});
        $display("frequency test done");
        conclude();
    end
endmodule
`default_nettype wire
